/* hw/value_function_defs.vh */
// constants for the value-function operator block
// values are signed fixed point, 2 decimal places (0.01 = 1 count)
`ifndef VALUE_FUNCTION_DEFS_VH
`define VALUE_FUNCTION_DEFS_VH

`define VF_W 32
`define VF_OP_W 4
// operation codes
`define VF_OP_ADD_CLAMP 4'h0
`define VF_OP_SUB_CLAMP 4'h1
`define VF_OP_MUL_CLAMP 4'h2
`define VF_OP_HOLD_ZERO 4'h3
`define VF_OP_MUL_ADD 4'h4
`define VF_OP_SCALED_SUM 4'h5
`define VF_OP_SCALED_DIFF 4'h6
`define VF_OP_RATIO_GAIN 4'h7
`define VF_OP_PRODUCT_GAIN 4'h8
`define VF_OP_PULSE_ON_RISE 4'h9
`define VF_OP_PULSE_ON_FALL 4'hA
`define VF_OP_FILTER 4'hB
`define VF_OP_SWITCH_CMP 4'hC
// fixed point scale: 1.0 = 100 counts
`define VF_ONE 32'h0000_0064
`define VF_HIGH 32'h0000_0001
`define VF_LOW 32'h0000_0000
// 32768.0 in counts
`define VF_RATIO_SAT 32'h0032_0000
// rescale factor of one product, and its square for the ratio
`define VF_SCALE 64'sh0000_0000_0000_0064
`define VF_SCALE_SQ 64'sh0000_0000_0000_2710
// 32-bit saturation limits held at product width
`define VF_SAT_POS 64'sh0000_0000_7FFF_FFFF
`define VF_SAT_NEG 64'shFFFF_FFFF_8000_0000
// execution tick period in ms; seconds are 100 counts so ms per count
`define VF_TICK_MS 32'h0000_0005
`define VF_MS_PER_COUNT 32'h0000_000A
// filter: one-tick alpha numerator scale, not used; the filter divides by delay_ticks + VF_FILT_DEN_BIAS
`define VF_FILT_K 32'h0000_0001
`define VF_FILT_DEN_BIAS 32'h0000_0001

`endif

/* hw/value_function_operator_set.v */
// value-function operator block: three signed inputs, a registered result output and a registered done flag
// assumes inputs are stable at each exec_tick pulse from the evaluation scheduler
// Function
// - c above zero: result greater than c becomes c
// - c zero or negative: result less than c becomes c
// - hold-or-zero: a>=b gives a, else a<=c gives 0, else hold
// - multiply-then-add: a*b plus c
// - scaled sum: a times (b+c)
// - scaled difference: a times (b-c)
// - ratio gain: a times (1 + b/c)
// - ratio gain with c zero: quotient is +32768.0 or -32768.0 by b sign, zero when b is zero
// - product gain: a times (1 + b*c)
// - rising edge of a drives 0.01 for b seconds
// - new rising edge during pulse restarts the whole delay
// - falling edge of a drives 0.01 for b seconds
// - new falling edge during pulse restarts the whole delay
// - pulse output inverted when c is nonzero
// - filter: first-order low-pass of a, time constant b seconds
// - switching comparator: a>b on, else a<c off, else hold
`timescale 1ns/100ps
`default_nettype none
`include "value_function_defs.vh"

module value_function_operator_set (
  input wire clock,
  input wire rst_n,
  input wire exec_tick,
  input wire [3:0] op_sel,
  input wire signed [31:0] in_a,
  input wire signed [31:0] in_b,
  input wire signed [31:0] in_c,
  output reg signed [31:0] result_r,
  output reg done_r
);

  reg signed [31:0] result_nxt;
  reg signed [31:0] prev_a_r;
  reg [31:0] pulse_cnt_r;
  reg [31:0] pulse_cnt_nxt;
  reg signed [47:0] filt_acc_r;
  reg signed [47:0] filt_acc_nxt;
  reg signed [63:0] wide;
  reg signed [31:0] quot;
  reg signed [31:0] tau_ticks;
  reg [31:0] delay_ticks;
  reg pulse_active;
  reg edge_seen;
  reg [31:0] b_pos;
  reg signed [47:0] a_fix;
  reg signed [48:0] filt_diff;
  reg signed [48:0] step;
  reg signed [48:0] filt_sum;
  reg signed [32:0] sum_bc;
  reg signed [32:0] diff_bc;

  // saturate a wide intermediate to the 32-bit output range
  function signed [31:0] sat32;
    input signed [63:0] v;
    begin
      if (v > `VF_SAT_POS)
        sat32 = 32'sh7FFF_FFFF;
      else if (v < `VF_SAT_NEG)
        sat32 = 32'sh8000_0000;
      else
        sat32 = v[31:0];
    end
  endfunction

  // scale a fixed point product back to 2 decimal places, saturating
  function signed [31:0] fx_scale;
    input signed [63:0] p;
    reg signed [63:0] q;
    begin
      q = p / `VF_SCALE;
      fx_scale = sat32(q);
    end
  endfunction

  // sign-dependent clamp by c, shared by the arithmetic clamp modes
  function signed [31:0] clamp_c;
    input signed [31:0] v;
    input signed [31:0] c;
    begin
      clamp_c = v;
      if (c > 32'sh0000_0000) begin
        if (v > c) clamp_c = c;
      end else begin
        if (v < c) clamp_c = c;
      end
    end
  endfunction

  // full-width product before the rescale, so nothing wraps at 32 bits
  function signed [31:0] fx_mul;
    input signed [31:0] x;
    input signed [31:0] y;
    reg signed [63:0] p;
    begin
      p = x;
      p = p * y;
      fx_mul = fx_scale(p);
    end
  endfunction

  // any nonzero value counts as logic high on a value input
  function is_high;
    input signed [31:0] v;
    begin
      is_high = (v != 32'sh0000_0000);
    end
  endfunction

  // one evaluation; state only moves on exec_tick
  always @* begin
    result_nxt = result_r;
    pulse_cnt_nxt = pulse_cnt_r;
    filt_acc_nxt = filt_acc_r;
    wide = 64'sh0000_0000_0000_0000;
    quot = 32'sh0000_0000;
    filt_diff = 49'sh0_0000_0000_0000;
    step = 49'sh0_0000_0000_0000;
    filt_sum = 49'sh0_0000_0000_0000;
    a_fix = $signed({in_a, 16'h0000});
    sum_bc = $signed({in_b[31], in_b}) + $signed({in_c[31], in_c});
    diff_bc = $signed({in_b[31], in_b}) - $signed({in_c[31], in_c});
    // negative seconds mean no delay at all
    b_pos = in_b[31] ? 32'h0000_0000 : in_b;
    // seconds in counts of 0.01 s, times ms per count, over tick period
    delay_ticks = b_pos * `VF_MS_PER_COUNT / `VF_TICK_MS;
    // plus one keeps the divider nonzero when b is zero
    tau_ticks = $signed(delay_ticks + `VF_FILT_DEN_BIAS);
    pulse_active = (pulse_cnt_r != 32'h0000_0000);
    edge_seen = 1'b0;
    case (op_sel)
      `VF_OP_ADD_CLAMP: begin
        wide = in_a + in_b;
        result_nxt = clamp_c(sat32(wide), in_c);
      end
      `VF_OP_SUB_CLAMP: begin
        wide = in_a - in_b;
        result_nxt = clamp_c(sat32(wide), in_c);
      end
      `VF_OP_MUL_CLAMP: result_nxt = clamp_c(fx_mul(in_a, in_b), in_c);
      `VF_OP_HOLD_ZERO: begin
        if (in_a >= in_b) result_nxt = in_a;
        else if (in_a <= in_c) result_nxt = `VF_LOW;
      end
      `VF_OP_MUL_ADD: begin
        // c joins before the rescale, so only one truncation happens
        wide = in_a * in_b + `VF_SCALE * in_c;
        result_nxt = fx_scale(wide);
      end
      `VF_OP_SCALED_SUM: begin
        wide = in_a * sum_bc;
        result_nxt = fx_scale(wide);
      end
      `VF_OP_SCALED_DIFF: begin
        wide = in_a * diff_bc;
        result_nxt = fx_scale(wide);
      end
      `VF_OP_RATIO_GAIN: begin
        if (!is_high(in_c)) begin
          // only the sign of b is defined; b zero gives zero quotient
          if (in_b > 32'sh0000_0000) quot = `VF_RATIO_SAT;
          else if (in_b < 32'sh0000_0000) quot = -$signed(`VF_RATIO_SAT);
        end else begin
          wide = `VF_SCALE_SQ * in_b / in_c;
          quot = fx_scale(wide);
        end
        wide = quot;
        wide = wide + $signed(`VF_ONE);
        result_nxt = fx_mul(in_a, sat32(wide));
      end
      `VF_OP_PRODUCT_GAIN: begin
        wide = fx_mul(in_b, in_c);
        wide = wide + $signed(`VF_ONE);
        result_nxt = fx_mul(in_a, sat32(wide));
      end
      `VF_OP_PULSE_ON_RISE, `VF_OP_PULSE_ON_FALL: begin
        if (op_sel == `VF_OP_PULSE_ON_RISE)
          edge_seen = is_high(in_a) && !is_high(prev_a_r);
        else
          edge_seen = !is_high(in_a) && is_high(prev_a_r);
        // a fresh edge reloads even mid-pulse, which is the retrigger
        if (edge_seen) pulse_cnt_nxt = delay_ticks;
        else if (pulse_active) pulse_cnt_nxt = pulse_cnt_r - 32'h0000_0001;
        pulse_active = (pulse_cnt_nxt != 32'h0000_0000);
        if (pulse_active ^ is_high(in_c)) result_nxt = `VF_HIGH;
        else result_nxt = `VF_LOW;
      end
      `VF_OP_FILTER: begin
        if (is_high(in_c)) begin
          filt_acc_nxt = a_fix;
        end else begin
          // signed all the way, or a falling input would blow up the step
          filt_diff = a_fix - filt_acc_r;
          step = filt_diff / tau_ticks;
          filt_sum = filt_acc_r + step;
          filt_acc_nxt = filt_sum[47:0];
        end
        result_nxt = filt_acc_nxt[47:16];
      end
      `VF_OP_SWITCH_CMP: begin
        if (in_a > in_b) result_nxt = `VF_HIGH;
        else if (in_a < in_c) result_nxt = `VF_LOW;
      end
      // unused codes hold the output
      default: result_nxt = result_r;
    endcase
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      result_r <= 32'sh0000_0000;
      prev_a_r <= 32'sh0000_0000;
      pulse_cnt_r <= 32'h0000_0000;
      filt_acc_r <= 48'sh0000_0000_0000;
      done_r <= 1'b0;
    end else begin
      done_r <= exec_tick;
      if (exec_tick) begin
        result_r <= result_nxt;
        prev_a_r <= in_a;
        pulse_cnt_r <= pulse_cnt_nxt;
        filt_acc_r <= filt_acc_nxt;
      end
    end
  end

endmodule
`default_nettype wire

/* dv/tick_source.sv */
// upstream block model: issues the evaluation tick
// assumes go is driven just after a rising edge
`timescale 1ns/100ps
`default_nettype none
module tick_source (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic go,
  output logic exec_tick
);
  // registered, so inputs already stand a full cycle before the tick
  always @(posedge clock or negedge rst_n)
    if (!rst_n) exec_tick <= 1'b0;
    else exec_tick <= go;
endmodule
`default_nettype wire

/* dv/vf_properties.sv */
// port checker for the value-function block
// assumes bind from the bench top file
`timescale 1ns/100ps
`default_nettype none
module vf_properties (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic exec_tick,
  input wire logic [3:0] op_sel,
  input wire logic signed [31:0] in_a,
  input wire logic signed [31:0] in_b,
  input wire logic signed [31:0] in_c,
  input wire logic signed [31:0] result_r,
  input wire logic done_r
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // wide products, no overflow before the rescale
  wire signed [63:0] ab = in_a * in_b;
  wire signed [63:0] as = in_a * (in_b + in_c);
  wire signed [63:0] ad = in_a * (in_b - in_c);
  AST_DONE: assert property (exec_tick |=> done_r) else $error("done missing");
  AST_QUIET: assert property (!exec_tick |=> !done_r && $stable(result_r)) else $error("output moved");
  AST_MULADD: assert property (exec_tick && op_sel == 4'h4 |=> result_r == ($past(ab) + 100 * $past(in_c)) / 100)
    else $error("mul add wrong");
  AST_SUM: assert property (exec_tick && op_sel == 4'h5 |=> result_r == $past(as) / 100)
    else $error("scaled sum wrong");
  AST_DIFF: assert property (exec_tick && op_sel == 4'h6 |=> result_r == $past(ad) / 100)
    else $error("scaled diff wrong");
  AST_CLAMP_HI: assert property (exec_tick && op_sel < 4'h3 && in_c > 0 |=> result_r <= $past(in_c))
    else $error("clamp high wrong");
  AST_CLAMP_LO: assert property (exec_tick && op_sel < 4'h3 && in_c <= 0 |=> result_r >= $past(in_c))
    else $error("clamp low wrong");
  AST_HOLD: assert property (exec_tick && op_sel == 4'h3 && in_a >= in_b |=> result_r == $past(in_a))
    else $error("hold zero wrong");
  AST_SWITCH: assert property (exec_tick && op_sel == 4'hC && in_a > in_b |=> result_r == 1)
    else $error("switch wrong");
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// self-checking bench for the value-function block
// assumes tick_source and vf_properties compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clock = 0, rst_n = 0, go = 0, exec_tick, done_r;
  logic [3:0] op_sel = 4'h0;
  logic signed [31:0] in_a = 0, in_b = 0, in_c = 0, result_r, a, b, c;
  logic [31:0] seed = 32'h0000_000A;
  logic [8:0] ra = 9'h1F6, re = 9'h0FE;
  logic [8:0] fa = 9'h005, fe = 9'h181;
  int fails = 0, total_checks = 0, cyc = 0, i;
  tick_source src (.clock, .rst_n, .go, .exec_tick);
  value_function_operator_set uut (.clock, .rst_n, .exec_tick, .op_sel, .in_a, .in_b, .in_c, .result_r, .done_r);
  initial forever #2.5 clock = ~clock;
  function automatic logic signed [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return $signed({22'h0, seed[9:0]}) - 512;
  endfunction
  // one evaluation: inputs held until the tick edge has taken them
  task automatic run(input logic [3:0] op, input logic signed [31:0] xa, xb, xc, exp);
    op_sel = op; in_a = xa; in_b = xb; in_c = xc; go = 1;
    @(posedge clock); #1 go = 0;
    @(posedge clock); #1;
    total_checks++;
    if (result_r !== exp || done_r !== 1'b1) begin
      fails++;
      $display("unexpected result_r op %0h: expected %0d seen %0d", op, exp, result_r);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ceiling well above the ~200 cycles the tests need
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (8) @(posedge clock);
    #1 rst_n = 1;
    // pulse first, so no edge history from other modes
    for (i = 0; i < 9; i++) run(4'h9, ra[i] ? 100 : 0, 2, 0, re[i]);
    for (i = 0; i < 9; i++) run(4'hA, fa[i] ? 100 : 0, 2, 1, fe[i]);
    $display("pulse test done");
    run(4'h0, 300, 200, 400, 400);
    run(4'h1, -300, 200, -100, -100);
    run(4'h2, 300, 200, -100, 600);
    run(4'h7, 300, 200, 100, 900);
    run(4'h7, 3, 5, 0, 98307);
    run(4'h7, 3, -5, 0, -98301);
    run(4'h7, 300, 0, 0, 300);
    run(4'h8, 100, 200, 300, 700);
    $display("arith test done");
    run(4'h3, 50, 40, 10, 50);
    run(4'h3, 30, 40, 10, 50);
    run(4'h3, 10, 40, 10, 0);
    run(4'hC, 50, 40, 10, 1);
    run(4'hC, 30, 40, 10, 1);
    run(4'hC, 5, 40, 10, 0);
    run(4'hB, 777, 0, 1, 777);
    run(4'hB, 2787, 100, 0, 787);
    run(4'hB, -1223, 100, 0, 777);
    $display("compare and filter test done");
    for (i = 0; i < 20; i++) begin
      a = rnd();
      b = rnd();
      c = rnd();
      run(4'h4, a, b, c, (a * b + 100 * c) / 100);
      run(4'h5, a, b, c, a * (b + c) / 100);
      run(4'h6, a, b, c, a * (b - c) / 100);
    end
    $display("random test done");
    tally_and_finish();
  end
endmodule
bind value_function_operator_set vf_properties chk (.clock, .rst_n, .exec_tick, .op_sel, .in_a, .in_b, .in_c,
  .result_r, .done_r);
`default_nettype wire
